// ==== bench/lmc_chk.sv ====
// Concurrent checks on the ports of the LCD multiplex controller.
`timescale 1ns/1ps
`default_nettype none

module lmc_chk (
  input wire logic clk, // Clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic stop_mode, // STOP level.
  input wire logic osc_fail, // Oscillator failure.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  input wire logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  input wire logic s_axi_wready, // Write data ready.
  input wire logic [1:0] s_axi_bresp, // Write response.
  input wire logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic s_axi_arvalid, // Read address valid.
  input wire logic s_axi_arready, // Read address ready.
  input wire logic [31:0] s_axi_rdata, // Read data.
  input wire logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire lmc_pkg::lmc_drive_s drive, // Drive levels.
  input wire lmc_pkg::lmc_bias_s bias // Bias enables.
);
  logic [2:0] src_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Last clock source written by software
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_q <= lmc_pkg::SRC_OFF;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
                 s_axi_awaddr == lmc_pkg::ADDR_MODE_CONTROL && s_axi_wstrb[0]) begin
      src_q <= s_axi_wdata[5:3];
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_stop_main;
    (stop_mode && src_q != lmc_pkg::SRC_AUX) [*2];
  endsequence
  sequence s_unbiased;
    !bias.divider_en [*2];
  endsequence

  AST_WR_ANSWER: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_STOP_MAIN: assert property (s_stop_main |-> drive == '0 && !bias.divider_en)
    else $error("outputs live in stop on main clock");
  AST_OSC_FAIL: assert property (osc_fail [*2] |-> drive == '0 && bias == '0)
    else $error("outputs live after oscillator failure");
  AST_BIAS_OFF: assert property (s_unbiased |-> drive == '0)
    else $error("lines driven with divider off");
  AST_TAPS: assert property (bias.taps_out_en |-> bias.divider_en)
    else $error("taps out without divider");
endmodule // lmc_chk

bind lmc_lcd_mux_controller lmc_chk i_lmc_chk (
  .clk(clk), .rst_n(rst_n), .stop_mode(stop_mode), .osc_fail(osc_fail),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .drive(drive), .bias(bias)
);
`default_nettype wire

// ==== bench/lmc_panel_model.sv ====
// Behavioural model of the passive LCD glass seen by the drive outputs.
`timescale 1ns/1ps
`default_nettype none

module lmc_panel_model (
  input wire lmc_pkg::lmc_drive_s drive, // Line levels from the controller.
  input wire lmc_pkg::lmc_bias_s bias, // Bias enables from the controller.
  output logic [lmc_pkg::SEG_COUNT-1:0] lit_bp1, // Elements lit on backplane one.
  output logic dark // Every line grounded and bias off.
);
  // ----------------------------------------------------------------
  // Element state
  // ----------------------------------------------------------------
  // Full supply lights.
  always_comb begin
    for (int k = 0; k < lmc_pkg::SEG_COUNT; k++) begin
      lit_bp1[k] = (drive.seg[k] == lmc_pkg::LV_GND && drive.com[0] == lmc_pkg::LV_FULL) ||
                   (drive.seg[k] == lmc_pkg::LV_FULL && drive.com[0] == lmc_pkg::LV_GND);
    end
  end
  assign dark = drive == '0 && bias == '0;
endmodule // lmc_panel_model
`default_nettype wire

// ==== bench/test_lcd_mux_controller.sv ====
// Self-checking testbench for the LCD multiplex controller.
`timescale 1ns/1ps
`default_nettype none

module test_lcd_mux_controller;
  // Clocks per base period with divide-by-32 and 512 Hz.
  localparam int BASE = 32 * 64;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic stop_mode = 1'h0;
  logic osc_fail = 1'h0;
  logic aux_osc_in = 1'h0;
  logic aux_run = 1'h0;
  logic [1:0] aux_div = 2'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'h0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'h0;
  lmc_pkg::lmc_drive_s drive;
  lmc_pkg::lmc_bias_s bias;
  logic [lmc_pkg::SEG_COUNT-1:0] lit_bp1;
  logic dark;
  int n_mismatch = 0;
  int n_compared = 0;

  lmc_lcd_mux_controller i_lmc_lcd_mux_controller (
    .clk(clk), .rst_n(rst_n), .stop_mode(stop_mode), .osc_fail(osc_fail),
    .aux_osc_in(aux_osc_in), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .drive(drive), .bias(bias)
  );
  lmc_panel_model i_lmc_panel_model (.drive(drive), .bias(bias), .lit_bp1(lit_bp1), .dark(dark));

  always #50 clk = ~clk;
  // Auxiliary oscillator stand-in: one reference tick every 8 clocks.
  always @(posedge clk) begin
    aux_div <= aux_div + 2'h1;
    if (aux_run && aux_div == 2'h3) aux_osc_in <= ~aux_osc_in;
  end

  // ----------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tmo(input string what);
    $display("mismatch %s expected answer seen timeout", what);
    n_mismatch++;
    conclude();
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int i;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'h1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) break;
      s_axi_bready <= (i > 1);
    end
    if (i == 40) tmo("bvalid");
    check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) break;
      s_axi_rready <= (i > 0);
    end
    if (i == 40) tmo("rvalid");
    check("rdata", ed, s_axi_rdata);
    check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wait_com(input logic [1:0] lvl, input int max, output int n);
    n = 0;
    while (drive.com[0] !== lvl) begin
      @(posedge clk);
      n++;
      if (n > max) tmo("backplane level");
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(lmc_pkg::ADDR_MODE_CONTROL, {24'h0, lmc_pkg::MODE_CONTROL_RESET}, 2'h0);
    wr(lmc_pkg::ADDR_MODE_CONTROL, 8'hD2, 2'h0);
    rd(lmc_pkg::ADDR_MODE_CONTROL, 32'h000000D2, 2'h0);
    wr(8'h60, 8'h55, 2'h2);
    rd(8'h60, 32'h00000000, 2'h2);
    $display("done registers");
  endtask
  task automatic t_ram;
    for (int i = 0; i < lmc_pkg::IMAGE_BYTES; i++) wr(8'(4 * i), 8'(i) ^ 8'hA5, 2'h0);
    for (int i = 0; i < lmc_pkg::IMAGE_BYTES; i++) rd(8'(4 * i), 32'(8'(i) ^ 8'hA5), 2'h0);
    $display("done image ram");
  endtask
  task automatic t_off;
    logic [7:0] codes [4] = '{8'h12, 8'h3E, 8'h00, 8'h1F};
    for (int i = 0; i < 4; i++) begin
      wr(lmc_pkg::ADDR_MODE_CONTROL, codes[i], 2'h0);
      cyc(3);
      check("dark", 32'h1, {31'h0, dark});
    end
    $display("done display off");
  endtask
  task automatic t_static;
    int n;
    wr(8'h00, 8'h80, 2'h0);
    wr(8'h04, 8'h01, 2'h0);
    wr(8'h14, 8'h80, 2'h0);
    wr(lmc_pkg::ADDR_MODE_CONTROL, 8'h5E, 2'h0);
    cyc(3);
    check("bias", 32'h3, {30'h0, bias});
    check("lit", 32'h7, {29'h0, lit_bp1[44], lit_bp1[5], lit_bp1[4]});
    check("unlit", 32'h0, {30'h0, lit_bp1[6], lit_bp1[0]});
    wait_com(lmc_pkg::LV_GND, BASE + 100, n);
    check("lit inverted", 32'h7, {29'h0, lit_bp1[44], lit_bp1[5], lit_bp1[4]});
    wait_com(lmc_pkg::LV_FULL, BASE + 100, n);
    check("static period", BASE, n);
    $display("done static");
  endtask
  task automatic t_modes;
    int n;
    for (int m = 3; m >= 0; m--) begin
      wr(lmc_pkg::ADDR_MODE_CONTROL, {2'(m), 6'h1E}, 2'h0);
      cyc(3);
      check("taps", {31'h0, 2'(m) != lmc_pkg::MUX_HALF}, {31'h0, bias.taps_out_en});
    end
    wait_com(lmc_pkg::LV_GND, 8 * BASE + 100, n);
    wait_com(lmc_pkg::LV_FULL, 4 * BASE + 100, n);
    wait_com(lmc_pkg::LV_GND, 4 * BASE + 100, n);
    check("quarter period", 4 * BASE, n);
    cyc(BASE);
    check("backplane step", 32'h2, {28'h0, drive.com[1], drive.com[0]});
    $display("done modes");
  endtask
  task automatic t_stop;
    int n;
    stop_mode <= 1'h1;
    cyc(3);
    check("dark", 32'h1, {31'h0, dark});
    stop_mode <= 1'h0;
    wr(lmc_pkg::ADDR_MODE_CONTROL, 8'h0E, 2'h0);
    aux_run <= 1'h1;
    stop_mode <= 1'h1;
    cyc(3);
    check("dark", 32'h1, {31'h0, dark});
    stop_mode <= 1'h0;
    // Software lets the current frame end before entering STOP again.
    cyc(4 * BASE + 100);
    stop_mode <= 1'h1;
    cyc(3);
    check("bias", 32'h3, {30'h0, bias});
    wait_com(lmc_pkg::LV_FULL, 8 * 512 + 100, n);
    stop_mode <= 1'h0;
    $display("done stop");
  endtask
  task automatic t_osc;
    osc_fail <= 1'h1;
    cyc(3);
    check("dark", 32'h1, {31'h0, dark});
    osc_fail <= 1'h0;
    cyc(3);
    check("bias", 32'h3, {30'h0, bias});
    $display("done oscillator failure");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    t_regs();
    t_ram();
    t_off();
    t_static();
    t_modes();
    t_stop();
    t_osc();
    conclude();
  end
endmodule // test_lcd_mux_controller
`default_nettype wire

// ==== hdl/lmc_lcd_mux_controller.sv ====
// Multiplexed LCD controller with image RAM and an AXI4-Lite register slave.
// Behaviour
// - Mux field selects one to four backplanes.
// - Frame-rate field sets base frequency, 111 reserved.
// - Static mode refreshes at base frequency.
// - Frame rate is base over backplane count.
// - Bias divider off whenever driver off.
// - Third taps driven except in half mode.
// - Image bit one turns element on.
// - Image RAM has no reset value.
// - Unused backplane bytes stay ordinary storage.
// - Six bytes per backplane, segment bit mapping.
// - STOP on main clock grounds all outputs.
// - Auxiliary clock keeps display through STOP.
// - Clock source change applies at frame end.
// - Mode control byte at DCh, three fields.
// - Clock-source field: off, aux, main dividers.
// - Oscillator failure grounds all outputs.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module lmc_lcd_mux_controller (
  input wire logic clk, // System clock, 10 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic stop_mode, // Core is in STOP, level.
  input wire logic osc_fail, // Clock supervisor reports failure, level.
  input wire logic aux_osc_in, // Auxiliary 32 kHz oscillator pin.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output lmc_pkg::lmc_drive_s drive, // Segment and backplane drive levels.
  output lmc_pkg::lmc_bias_s bias // Bias divider and tap enables.
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] backplane_count(input logic [1:0] mux);
    case (mux)
      lmc_pkg::MUX_STATIC: backplane_count = 3'd1;
      lmc_pkg::MUX_HALF: backplane_count = 3'd2;
      lmc_pkg::MUX_THIRD: backplane_count = 3'd3;
      default: backplane_count = 3'd4;
    endcase
  endfunction

  function automatic logic src_valid(input logic [2:0] src);
    case (src)
      lmc_pkg::SRC_AUX, lmc_pkg::SRC_DIV32, lmc_pkg::SRC_DIV64,
      lmc_pkg::SRC_DIV128, lmc_pkg::SRC_DIV256: src_valid = 1'b1;
      default: src_valid = 1'b0;
    endcase
  endfunction

  function automatic logic [9:0] rate_div(input logic [2:0] rate);
    case (rate)
      3'h0: rate_div = lmc_pkg::RATE_DIV_64;
      3'h1: rate_div = lmc_pkg::RATE_DIV_85;
      3'h2: rate_div = lmc_pkg::RATE_DIV_128;
      3'h3: rate_div = lmc_pkg::RATE_DIV_171;
      3'h4: rate_div = lmc_pkg::RATE_DIV_256;
      3'h5: rate_div = lmc_pkg::RATE_DIV_341;
      default: rate_div = lmc_pkg::RATE_DIV_512;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Registers and storage
  // ----------------------------------------------------------------
  logic [7:0] mode_control;
  logic [7:0] image [lmc_pkg::IMAGE_BYTES];
  logic [2:0] active_src;
  logic [8:0] main_cnt;
  logic [9:0] base_cnt;
  logic [1:0] phase;
  logic polarity;
  logic [2:0] aux_sync;
  logic aux_level;
  logic osc_fail_seen;

  logic [1:0] mux_sel;
  logic [2:0] rate_sel;
  logic [2:0] n_bp;
  logic [8:0] main_div;
  logic aux_rise;
  logic ref_tick;
  logic phase_tick;
  logic frame_end;
  logic running;

  assign mux_sel = mode_control[lmc_pkg::MUX_MSB:lmc_pkg::MUX_LSB];
  assign rate_sel = mode_control[lmc_pkg::RATE_MSB:lmc_pkg::RATE_LSB];
  assign n_bp = backplane_count(mux_sel);

  assign running = src_valid(active_src) && (rate_sel != lmc_pkg::RATE_RESERVED) &&
                   !osc_fail && !(stop_mode && (active_src != lmc_pkg::SRC_AUX));

  // ----------------------------------------------------------------
  // Auxiliary oscillator input
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_sync <= 3'h0;
    end else begin
      aux_sync <= {aux_sync[1:0], aux_osc_in};
    end
  end

  // The level follows the pin once the second and third stages agree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_level <= 1'b0;
    end else if (aux_sync[1] == aux_sync[2]) begin
      aux_level <= aux_sync[2];
    end
  end

  assign aux_rise = (aux_sync[1] == aux_sync[2]) && aux_sync[2] && !aux_level;

  // ----------------------------------------------------------------
  // Reference clock selection
  // ----------------------------------------------------------------
  always_comb begin
    case (active_src)
      lmc_pkg::SRC_DIV32: main_div = lmc_pkg::MAIN_DIV32;
      lmc_pkg::SRC_DIV64: main_div = lmc_pkg::MAIN_DIV64;
      lmc_pkg::SRC_DIV128: main_div = lmc_pkg::MAIN_DIV128;
      default: main_div = lmc_pkg::MAIN_DIV256;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_cnt <= 9'h0;
    end else if (!running || (active_src == lmc_pkg::SRC_AUX) || (main_cnt == main_div - 9'd1)) begin
      main_cnt <= 9'h0;
    end else begin
      main_cnt <= main_cnt + 9'd1;
    end
  end

  assign ref_tick = running && ((active_src == lmc_pkg::SRC_AUX) ? aux_rise :
                                (main_cnt == main_div - 9'd1));

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  assign phase_tick = ref_tick && (base_cnt == rate_div(rate_sel) - 10'd1);
  assign frame_end = phase_tick && ({1'b0, phase} == n_bp - 3'd1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_cnt <= 10'h0;
    end else if (!running || phase_tick) begin
      base_cnt <= 10'h0;
    end else if (ref_tick) begin
      base_cnt <= base_cnt + 10'd1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
    end else if (!running || frame_end || ({1'b0, phase} >= n_bp)) begin
      phase <= 2'h0;
    end else if (phase_tick) begin
      phase <= phase + 2'd1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      polarity <= 1'b0;
    end else if (!running) begin
      polarity <= 1'b0;
    end else if (frame_end) begin
      polarity <= !polarity;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_src <= lmc_pkg::SRC_OFF;
    end else if (frame_end || !src_valid(active_src) || osc_fail) begin
      active_src <= mode_control[lmc_pkg::SRC_MSB:lmc_pkg::SRC_LSB];
    end
  end

  // Failure flag is sticky until the mode control register is written.
  logic ctrl_write;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_fail_seen <= 1'b0;
    end else if (osc_fail) begin
      osc_fail_seen <= 1'b1;
    end else if (ctrl_write) begin
      osc_fail_seen <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  lmc_pkg::lmc_drive_s next_drive;

  genvar gi;
  generate
    for (gi = 0; gi < lmc_pkg::SEG_COUNT; gi++) begin : g_seg
      localparam int POS = gi + lmc_pkg::SEG_FIRST - 1;
      logic on_bit;
      assign on_bit = image[5'(int'(phase) * lmc_pkg::BYTES_PER_BACKPLANE + POS / 8)][POS % 8];
      assign next_drive.seg[gi] = !running ? lmc_pkg::LV_GND :
                                  on_bit ? (polarity ? lmc_pkg::LV_FULL : lmc_pkg::LV_GND) :
                                  (polarity ? lmc_pkg::LV_THIRD : lmc_pkg::LV_TWO_THIRDS);
    end
    for (gi = 0; gi < lmc_pkg::COM_COUNT; gi++) begin : g_com
      assign next_drive.com[gi] = !running ? lmc_pkg::LV_GND :
                                  (phase == 2'(gi)) ?
                                  (polarity ? lmc_pkg::LV_GND : lmc_pkg::LV_FULL) :
                                  (polarity ? lmc_pkg::LV_TWO_THIRDS : lmc_pkg::LV_THIRD);
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive <= '0;
    end else begin
      drive <= next_drive;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bias <= '0;
    end else begin
      bias.divider_en <= running;
      bias.taps_out_en <= running && (mux_sel != lmc_pkg::MUX_HALF);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic [7:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane;
  logic do_write;
  logic wr_image;

  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_image = (wr_addr <= lmc_pkg::ADDR_IMAGE_LAST) && (wr_addr[1:0] == 2'h0);
  assign ctrl_write = do_write && wr_lane && (wr_addr == lmc_pkg::ADDR_MODE_CONTROL);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      wr_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      wr_addr <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_wready <= 1'b1;
      wr_byte <= 8'h00;
      wr_lane <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wr_byte <= s_axi_wdata[7:0];
      wr_lane <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_image || (wr_addr == lmc_pkg::ADDR_MODE_CONTROL) ||
                      (wr_addr == lmc_pkg::ADDR_STATUS)) ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_control <= lmc_pkg::MODE_CONTROL_RESET;
    end else if (ctrl_write) begin
      mode_control <= wr_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (do_write && wr_lane && wr_image) begin
      image[5'(wr_addr[7:2])] <= wr_byte;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [7:0] status;
  assign status = {active_src, osc_fail_seen, polarity, phase, running};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      if ((s_axi_araddr <= lmc_pkg::ADDR_IMAGE_LAST) && (s_axi_araddr[1:0] == 2'h0)) begin
        s_axi_rdata <= {24'h0, image[5'(s_axi_araddr[7:2])]};
      end else if (s_axi_araddr == lmc_pkg::ADDR_MODE_CONTROL) begin
        s_axi_rdata <= {24'h0, mode_control};
      end else if (s_axi_araddr == lmc_pkg::ADDR_STATUS) begin
        s_axi_rdata <= {24'h0, status};
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= 2'h2;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // lmc_lcd_mux_controller

`default_nettype wire

// ==== hdl/lmc_pkg.sv ====
// Constants, field layouts and drive carrier types for the LCD multiplex controller.
package lmc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IMAGE_BASE = 8'h00;
  localparam logic [7:0] ADDR_IMAGE_LAST = 8'h5C;
  localparam logic [7:0] ADDR_MODE_CONTROL = 8'hDC;
  localparam logic [7:0] ADDR_STATUS = 8'hE0;
  localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
  localparam int IMAGE_BYTES = 24;
  localparam int BYTES_PER_BACKPLANE = 6;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int MUX_MSB = 7;
  localparam int MUX_LSB = 6;
  localparam int SRC_MSB = 5;
  localparam int SRC_LSB = 3;
  localparam int RATE_MSB = 2;
  localparam int RATE_LSB = 0;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int ST_RUNNING = 0;
  localparam int ST_PHASE_LSB = 1;
  localparam int ST_POLARITY = 3;
  localparam int ST_OSC_FAIL = 4;
  localparam int ST_SRC_LSB = 5;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MUX_QUARTER = 2'h0;
  localparam logic [1:0] MUX_STATIC = 2'h1;
  localparam logic [1:0] MUX_HALF = 2'h2;
  localparam logic [1:0] MUX_THIRD = 2'h3;

  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam logic [2:0] SRC_AUX = 3'h1;
  localparam logic [2:0] SRC_DIV32 = 3'h3;
  localparam logic [2:0] SRC_DIV64 = 3'h4;
  localparam logic [2:0] SRC_DIV128 = 3'h5;
  localparam logic [2:0] SRC_DIV256 = 3'h6;

  localparam logic [2:0] RATE_RESERVED = 3'h7;

  // Drive levels: ground, one third, two thirds, full display supply.
  localparam logic [1:0] LV_GND = 2'h0;
  localparam logic [1:0] LV_THIRD = 2'h1;
  localparam logic [1:0] LV_TWO_THIRDS = 2'h2;
  localparam logic [1:0] LV_FULL = 2'h3;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int REF_HZ = 32768;
  localparam logic [8:0] MAIN_DIV32 = 9'd32;
  localparam logic [8:0] MAIN_DIV64 = 9'd64;
  localparam logic [8:0] MAIN_DIV128 = 9'd128;
  localparam logic [8:0] MAIN_DIV256 = 9'd256;
  // Reference periods per base frame period: 64, 85, 128, 171, 256, 341, 512 Hz.
  localparam logic [9:0] RATE_DIV_64 = 10'(REF_HZ / 64);
  localparam logic [9:0] RATE_DIV_85 = 10'd384;
  localparam logic [9:0] RATE_DIV_128 = 10'(REF_HZ / 128);
  localparam logic [9:0] RATE_DIV_171 = 10'd192;
  localparam logic [9:0] RATE_DIV_256 = 10'(REF_HZ / 256);
  localparam logic [9:0] RATE_DIV_341 = 10'd96;
  localparam logic [9:0] RATE_DIV_512 = 10'(REF_HZ / 512);

  // ----------------------------------------------------------------
  // Output carrier
  // ----------------------------------------------------------------
  localparam int SEG_COUNT = 45;
  localparam int SEG_FIRST = 4;
  localparam int COM_COUNT = 4;

  typedef struct packed {
    logic [SEG_COUNT-1:0][1:0] seg;
    logic [COM_COUNT-1:0][1:0] com;
  } lmc_drive_s;

  typedef struct packed {
    logic divider_en;
    logic taps_out_en;
  } lmc_bias_s;

endpackage
